// >>> hw/dlspc_fifo.sv
// Request FIFO with registered read data and valid/ready on both sides
module dlspc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_in,    // Core clock
    input  wire logic             srst_in,   // Sync reset, high
    input  wire logic [WIDTH-1:0] wr_data_in, // Write word
    input  wire logic             wr_valid_in, // Write offered
    output logic                  wr_ready_out, // Room available
    output logic [WIDTH-1:0]      rd_data_out, // Head word, registered
    output logic                  rd_valid_out, // Head valid
    input  wire logic             rd_ready_in   // Head taken
);
    localparam int AW = $clog2(DEPTH);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
        $error("dlspc_fifo: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wp_r;
    logic [AW:0]      rp_r;
    logic [WIDTH-1:0] rd_data_r;
    logic             rd_valid_r;

    // Pointer based fullness
    wire empty_w = (wp_r == rp_r);
    wire full_w  = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    wire push_w  = wr_valid_in && !full_w;
    wire load_w  = !empty_w && (!rd_valid_r || rd_ready_in);

    assign wr_ready_out = !full_w;
    assign rd_data_out  = rd_data_r;
    assign rd_valid_out = rd_valid_r;

    // Storage write
    always_ff @(posedge clk_in) begin
        if (push_w) begin
            mem_r[wp_r[AW-1:0]] <= wr_data_in;
        end
    end

    // Pointers and output register
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wp_r       <= '0;
            rp_r       <= '0;
            rd_valid_r <= 1'b0;
            rd_data_r  <= '0;
        end else begin
            if (push_w) begin
                wp_r <= wp_r + 1'b1;
            end
            if (load_w) begin
                rd_data_r  <= mem_r[rp_r[AW-1:0]];
                rp_r       <= rp_r + 1'b1;
                rd_valid_r <= 1'b1;
            end else if (rd_ready_in) begin
                rd_valid_r <= 1'b0;
            end
        end
    end
endmodule : dlspc_fifo

// >>> hw/dlspc_host.sv
// Host end of the serial display link: short packet framer and reader
// How it works
// - Sync events use codes 01, 11, 21, 31.
// - Host sends sync starts and ends paired.
// - Code 08 packet marks high-speed burst end.
// - No end packet in low-power sending.
// - Receivers detect end packet in every mode.
// - End packet fixed: 08, channel 0, 0f0f, 01.
// - End packet channel always zero.
// - Generic writes 03, 13, 23, four bytes.
// - Type bits 5:4 count parameters; pad zero. Only 13 and 14 get a zero second byte; 03 and 04 pass unchanged.
// - Generic reads 04, 14, 24; any reply.
// - Oversized reads split over separate transmissions.
// - After a read, hand the bus over.
// - Read request ends its transmission.
// - Short packet is identifier, two bytes, check.
module dlspc_host
    import dlspc_pkg::*;
#(
    parameter int FIFO_DEPTH = 16,
    parameter int HALF_DIV   = HALF_CYC,
    parameter int TMO_BITS   = RX_TMO_BITS
) (
    input  wire logic       clk_in,          // Core clock, 250 MHz
    input  wire logic       srst_in,         // Sync reset, high
    input  wire dlspc_pkt_t req_pkt_in,      // Packet to send
    input  wire logic       req_valid_in,    // Packet offered
    output logic            req_ready_out,   // FIFO has room
    input  wire logic       end_of_transmission_packet_en_in,      // Append end packets
    output dlspc_pkt_t      rsp_pkt_out,     // Received reply
    output logic            rsp_valid_out,   // Reply pulse
    output logic            end_of_transmission_packet_seen_out,   // End packet received
    output logic            rx_tmo_out,      // Reply timed out
    output logic            busy_out,        // Transmission or read
    output logic            lnk_clk_out,     // Forward link clock
    output logic            lnk_hs_out,      // High-speed burst
    input  wire logic       lnk_dat_in,      // Data pin, in
    output logic            lnk_dat_out,     // Data pin, out
    output logic            lnk_dat_oe_out   // Data pin, drive
);
    // ------------------------------------------------------------------
    // Checks and types
    // ------------------------------------------------------------------
    if (HALF_DIV < 1 || TMO_BITS < 2 || FIFO_DEPTH < 2) begin : g_chk
        $error("dlspc_host: parameter out of range");
    end

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_TX   = 3'b001,
        ST_TURN = 3'b010,
        ST_WAIT = 3'b011,
        ST_RX   = 3'b100
    } dlspc_state_t;

    localparam int          CW       = $clog2(HALF_DIV + 1);
    localparam int          TW       = $clog2(TMO_BITS + 1);
    localparam logic [5:0]  LAST_BIT = 6'(PKT_BITS);
    localparam logic [5:0]  RX_LAST  = 6'(PKT_BITS - 1);
    localparam logic [CW-1:0] DIV_END = CW'(HALF_DIV - 1);
    localparam logic [TW-1:0] TMO_END = TW'(TMO_BITS - 1);

    // Fixed end packet
    localparam dlspc_pkt_t END_OF_TRANSMISSION_PACKET_PKT = '{ecc: END_OF_TRANSMISSION_PACKET_ECC,
                                        b1: END_OF_TRANSMISSION_PACKET_PAYLD[15:8],
                                        b0: END_OF_TRANSMISSION_PACKET_PAYLD[7:0],
                                        vc: END_OF_TRANSMISSION_PACKET_VC,
                                        dt: DT_END_OF_TRANSMISSION_PACKET};

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    // Generic read family request
    function automatic logic is_read(input dlspc_pkt_t p);
        is_read = (p.dt[3:0] == DT_GRD_LO) && (p.dt[5:4] != 2'h3);
    endfunction : is_read

    // End packet recognised by its fixed fields
    function automatic logic is_end_of_transmission_packet(input dlspc_pkt_t p);
        is_end_of_transmission_packet = (p == END_OF_TRANSMISSION_PACKET_PKT);
    endfunction : is_end_of_transmission_packet

    // ------------------------------------------------------------------
    // Request FIFO
    // ------------------------------------------------------------------
    dlspc_pkt_t fifo_pkt;
    logic       fifo_valid;
    logic       fifo_take;

    dlspc_fifo #(
        .WIDTH ($bits(dlspc_pkt_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in       (clk_in),
        .srst_in      (srst_in),
        .wr_data_in   (req_pkt_in),
        .wr_valid_in  (req_valid_in),
        .wr_ready_out (req_ready_out),
        .rd_data_out  (fifo_pkt),
        .rd_valid_out (fifo_valid),
        .rd_ready_in  (fifo_take)
    );

    // ------------------------------------------------------------------
    // Link clock divider
    // ------------------------------------------------------------------
    logic [CW-1:0] div_r;
    logic          lclk_r;
    wire           half_en = (div_r == DIV_END);
    wire           fall_en = half_en && lclk_r;   // Launch edge
    wire           rise_en = half_en && !lclk_r;  // Sample edge

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            div_r  <= '0;
            lclk_r <= 1'b0;
        end else begin
            div_r  <= half_en ? '0 : div_r + 1'b1;
            lclk_r <= lclk_r ^ half_en;
        end
    end

    // Data pin synchroniser
    logic din_m_r;
    logic din_s_r;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            din_m_r <= 1'b0;
            din_s_r <= 1'b0;
        end else begin
            din_m_r <= lnk_dat_in;
            din_s_r <= din_m_r;
        end
    end

    // ------------------------------------------------------------------
    // Packet shaping
    // ------------------------------------------------------------------
    // One parameter generic packets carry a zero second byte
    wire        gen_one = ((fifo_pkt.dt[3:0] == DT_GWR_LO) ||
                           (fifo_pkt.dt[3:0] == DT_GRD_LO)) &&
                          (fifo_pkt.dt[5:4] == PCOUNT_ONE);
    wire dlspc_pkt_t req_shaped = '{ecc: fifo_pkt.ecc,
                                    b1: gen_one ? PARAM_ZERO : fifo_pkt.b1,
                                    b0: fifo_pkt.b0,
                                    vc: fifo_pkt.vc,
                                    dt: fifo_pkt.dt};
    // Sync, colour, power and write codes other than 13 pass through unchanged

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    dlspc_state_t st_r;
    dlspc_state_t st_nxt;
    logic [32:0]  sh_r;
    logic [5:0]   bit_r;
    logic         rd_pend_r;   // Current burst ends in a read
    logic         eot_r;       // End packet is on the wire
    logic [TW-1:0] tmo_r;
    logic         hs_r;
    logic         oe_r;
    dlspc_pkt_t   rsp_r;
    logic         rsp_v_r;
    logic         eot_seen_r;
    logic         tmo_p_r;

    wire tx_last  = (st_r == ST_TX) && fall_en && (bit_r == LAST_BIT);
    wire rx_last  = (st_r == ST_RX) && rise_en && (bit_r == RX_LAST);
    wire logic [31:0] rx_word = {din_s_r, sh_r[32:2]};
    wire dlspc_pkt_t rx_pkt = rx_word[31:0];
    wire send_eot = end_of_transmission_packet_en_in && !eot_r;
    wire more_req = fifo_valid && !rd_pend_r;
    wire start_tx = (st_r == ST_IDLE) && fall_en && fifo_valid;
    wire next_req = tx_last && !eot_r && more_req;
    wire next_eot = tx_last && !next_req && send_eot;
    wire rx_start = (st_r == ST_WAIT) && rise_en && din_s_r;
    wire rx_tmo   = (st_r == ST_WAIT) && rise_en && !din_s_r &&
                    (tmo_r == TMO_END);

    assign fifo_take = start_tx || next_req;

    // Next state
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE: begin
                if (start_tx) begin
                    st_nxt = ST_TX;
                end
            end
            ST_TX: begin
                if (tx_last && !next_req && !next_eot) begin
                    st_nxt = rd_pend_r ? ST_TURN : ST_IDLE;
                end
            end
            ST_TURN: begin
                if (fall_en) begin
                    st_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (rx_start) begin
                    st_nxt = ST_RX;
                end else if (rx_tmo) begin
                    st_nxt = ST_IDLE;
                end
            end
            ST_RX: begin
                if (rx_last) begin
                    st_nxt = is_end_of_transmission_packet(rx_pkt) ? ST_IDLE : ST_WAIT;
                end
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    // State and shifter
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            st_r      <= ST_IDLE;
            sh_r      <= '0;
            bit_r     <= '0;
            rd_pend_r <= 1'b0;
            eot_r     <= 1'b0;
        end else begin
            st_r <= st_nxt;
            if (start_tx || next_req) begin
                sh_r      <= {req_shaped, 1'b1};
                bit_r     <= '0;
                rd_pend_r <= is_read(fifo_pkt);
                eot_r     <= 1'b0;
            end else if (next_eot) begin
                sh_r  <= {END_OF_TRANSMISSION_PACKET_PKT, 1'b1};
                bit_r <= '0;
                eot_r <= 1'b1;
            end else if (st_r == ST_TX && fall_en) begin
                sh_r  <= {1'b0, sh_r[32:1]};
                bit_r <= bit_r + 1'b1;
            end else if (rx_start) begin
                bit_r <= '0;
            end else if (st_r == ST_RX && rise_en) begin
                sh_r  <= {din_s_r, sh_r[32:1]};
                bit_r <= bit_r + 1'b1;
            end else if (st_r == ST_IDLE) begin
                rd_pend_r <= 1'b0;
                eot_r     <= 1'b0;
            end
        end
    end

    // Pin drive, timeout and reply outputs
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            hs_r       <= 1'b0;
            oe_r       <= 1'b0;
            tmo_r      <= '0;
            rsp_r      <= '0;
            rsp_v_r    <= 1'b0;
            eot_seen_r <= 1'b0;
            tmo_p_r    <= 1'b0;
        end else begin
            hs_r       <= (st_nxt == ST_TX);
            // Idle drive waits for a falling link edge, so a peripheral
            // still holding its last reply bit is never overdriven
            oe_r       <= (st_nxt == ST_TX) ||
                          ((st_nxt == ST_IDLE) && (oe_r || fall_en));
            tmo_r      <= (st_r == ST_WAIT) ?
                          (rise_en ? tmo_r + 1'b1 : tmo_r) : '0;
            // Replies forwarded as received, error reports included
            rsp_v_r    <= rx_last && !is_end_of_transmission_packet(rx_pkt);
            eot_seen_r <= rx_last && is_end_of_transmission_packet(rx_pkt);
            tmo_p_r    <= rx_tmo;
            if (rx_last) begin
                rsp_r <= rx_pkt;
            end
        end
    end

    assign lnk_clk_out    = lclk_r;
    assign lnk_hs_out     = hs_r;
    assign lnk_dat_out    = (st_r == ST_TX) ? sh_r[0] : 1'b0;
    assign lnk_dat_oe_out = oe_r;
    assign rsp_pkt_out    = rsp_r;
    assign rsp_valid_out  = rsp_v_r;
    assign end_of_transmission_packet_seen_out  = eot_seen_r;
    assign rx_tmo_out     = tmo_p_r;
    assign busy_out       = (st_r != ST_IDLE);
    // left to software: one read per request packet

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    sequence s_read_sent;
        tx_last && rd_pend_r && !next_eot;
    endsequence
    sequence s_release;
        ##1 (st_r == ST_TURN) ##1 !lnk_dat_oe_out;
    endsequence

    read_turns_a: assert property (s_read_sent |-> s_release)
        else $error("bus not released after read");
    read_last_a: assert property (tx_last && rd_pend_r |-> !next_req)
        else $error("packet sent after read request");
    eot_fixed_a: assert property (next_eot |=> sh_r[32:1] == 32'h010f0f08)
        else $error("end packet malformed");
    eot_vc_a: assert property (next_eot |=> sh_r[8:7] == 2'h0)
        else $error("end packet channel not zero");
    eot_gate_a: assert property (next_eot |-> end_of_transmission_packet_en_in)
        else $error("end packet sent while disabled");
    eot_hs_a: assert property (eot_r && st_r == ST_TX |-> lnk_hs_out)
        else $error("end packet outside high speed");
    pad_zero_a: assert property ((start_tx || next_req) && gen_one
                                 |=> sh_r[24:17] == 8'h00)
        else $error("single parameter not zero padded");
    eot_detect_a: assert property (rx_last && is_end_of_transmission_packet(rx_pkt)
                                   |=> end_of_transmission_packet_seen_out && !busy_out)
        else $error("received end packet missed");
    rsp_pass_a: assert property (rx_last && !is_end_of_transmission_packet(rx_pkt)
                                 |=> rsp_valid_out &&
                                     rsp_pkt_out == $past(rx_pkt))
        else $error("reply not forwarded");
    pkt_len_a: assert property ($rose(st_r == ST_TX)
                                |-> ##[1:1000] tx_last)
        else $error("packet length wrong");
endmodule : dlspc_host

// >>> hw/dlspc_pkg.sv
// Shared constants and types for the short packet link host
package dlspc_pkg;
    // ------------------------------------------------------------------
    // Data type codes
    // ------------------------------------------------------------------
    localparam logic [5:0] DT_VS_START  = 6'h01;
    localparam logic [5:0] DT_VS_END    = 6'h11;
    localparam logic [5:0] DT_HS_START  = 6'h21;
    localparam logic [5:0] DT_HS_END    = 6'h31;
    localparam logic [5:0] DT_END_OF_TRANSMISSION_PACKET      = 6'h08;
    localparam logic [5:0] DT_CM_OFF    = 6'h02;
    localparam logic [5:0] DT_CM_ON     = 6'h12;
    localparam logic [5:0] DT_SHUTDOWN  = 6'h22;
    localparam logic [5:0] DT_TURN_ON   = 6'h32;
    localparam logic [5:0] DT_GWR_0     = 6'h03;
    localparam logic [5:0] DT_GWR_1     = 6'h13;
    localparam logic [5:0] DT_GWR_2     = 6'h23;
    localparam logic [5:0] DT_GRD_0     = 6'h04;
    localparam logic [5:0] DT_GRD_1     = 6'h14;
    localparam logic [5:0] DT_GRD_2     = 6'h24;
    // Low nibble shared by the generic write and read families
    localparam logic [3:0] DT_GWR_LO    = 4'h3;
    localparam logic [3:0] DT_GRD_LO    = 4'h4;
    localparam logic [1:0] PCOUNT_ONE   = 2'h1;
    // ------------------------------------------------------------------
    // Fixed end-of-transmission packet fields
    // ------------------------------------------------------------------
    localparam logic [1:0]  END_OF_TRANSMISSION_PACKET_VC     = 2'h0;
    localparam logic [15:0] END_OF_TRANSMISSION_PACKET_PAYLD  = 16'h0f0f;
    localparam logic [7:0]  END_OF_TRANSMISSION_PACKET_ECC    = 8'h01;
    localparam logic [7:0]  PARAM_ZERO  = 8'h00;
    // ------------------------------------------------------------------
    // Framing and timing
    // ------------------------------------------------------------------
    localparam int          PKT_BITS    = 32;   // Four bytes per packet
    localparam int          CLK_PS      = 4000; // Core clock period, ps
    localparam int          LNK_PS      = 48000; // Link clock period, ps
    localparam int          HALF_CYC    = LNK_PS / (2 * CLK_PS);
    localparam int          RX_TMO_BITS = 256;  // Idle bits before give-up
    localparam int          MAX_RET_DEF = 1;    // Peripheral default size

    // Short packet as carried between user and framer
    typedef struct packed {
        logic [7:0] ecc;
        logic [7:0] b1;
        logic [7:0] b0;
        logic [1:0] vc;
        logic [5:0] dt;
    } dlspc_pkt_t;
endpackage : dlspc_pkg

// >>> tb/dlspc_periph_model.sv
// Behavioural display peripheral on the far side of the link
module dlspc_periph_model
    import dlspc_pkg::*;
#(
    parameter logic [5:0] RD_DT  = 6'h21, // Read reply code
    parameter logic [5:0] ERR_DT = 6'h02  // Error report code
) (
    input  wire logic srst_in,    // Sync reset, high
    input  wire logic lnk_clk_in, // Forward link clock
    input  wire logic lnk_hs_in,  // High-speed burst
    input  wire logic line_in,    // Resolved data line
    input  wire logic host_oe_in, // Host drives line
    output logic      dat_out,    // Reply data
    output logic      oe_out      // Reply drive
);
    timeunit 1ns;
    timeprecision 1ps;
    dlspc_pkt_t  got_q[$];     // Packets taken from the host
    dlspc_pkt_t  last_rd;      // Latest read request
    logic [31:0] sh;           // Receive shifter
    int          cnt = -1;     // Bit count, -1 hunts start bit
    int          mode = 0;     // 0 clean, 1 fixed, 2 bad, 3 mute
    int          delay = 2;    // Reply delay in link periods
    int          line_starts = 0;
    int          max_ret = MAX_RET_DEF;
    logic        second_field = 1'b0;
    logic        low_colour = 1'b0;
    logic        disp_on = 1'b1;
    logic        pend = 1'b0;
    // ------------------------------------------------------------------
    // Receive and act
    // ------------------------------------------------------------------
    // Start bit, then 32 bits lowest first, sampled on rising link edge
    always @(posedge lnk_clk_in) begin
        if (srst_in) begin
            cnt = -1;
            pend = 1'b0;
            max_ret = MAX_RET_DEF;
        end else if (lnk_hs_in && host_oe_in) begin
            if (cnt < 0) begin
                if (line_in) cnt = 0;
            end else begin
                sh[cnt] = line_in;
                cnt++;
                if (cnt == PKT_BITS) begin
                    cnt = -1;
                    take(dlspc_pkt_t'(sh));
                end
            end
        end
    end
    // Display reaction; link side keeps listening while dark
    task automatic take(input dlspc_pkt_t p);
        got_q.push_back(p);
        case (p.dt)
            DT_VS_START, DT_VS_END: if (!second_field) line_starts++;
            DT_HS_START: line_starts++;
            DT_CM_OFF:   low_colour = 1'b0;
            DT_CM_ON:    low_colour = 1'b1;
            DT_SHUTDOWN: disp_on = 1'b0;
            DT_TURN_ON:  disp_on = 1'b1;
            DT_GRD_0, DT_GRD_1, DT_GRD_2: begin
                last_rd = p;
                pend = 1'b1;
            end
            default: ;
        endcase
    endtask : take
    // One reply packet launched on falling link edges, then release
    task automatic send(input logic [31:0] w);
        @(negedge lnk_clk_in);
        oe_out = 1'b1;
        dat_out = 1'b1;
        for (int i = 0; i < PKT_BITS; i++) begin
            @(negedge lnk_clk_in);
            dat_out = w[i];
        end
        @(negedge lnk_clk_in);
        oe_out = 1'b0;
        dat_out = 1'b0;
    endtask : send
    // Answer a read once the host hands the line over
    initial begin
        dat_out = 1'b0;
        oe_out = 1'b0;
        forever begin
            wait (pend && !host_oe_in);
            repeat (delay) @(negedge lnk_clk_in);
            if (mode == 2) send({8'h00, 16'h0001, 2'h0, ERR_DT});
            if (mode < 2) send({8'h00, last_rd.b1, last_rd.b0, 2'h0, RD_DT});
            if (mode == 1) send({8'h00, 16'h0001, 2'h0, ERR_DT});
            if (mode < 3) send({8'h01, 16'h0f0f, 2'h0, 6'h08});
            pend = 1'b0;
        end
    end
endmodule : dlspc_periph_model

// >>> tb/testbench.sv
// Self-checking bench for the short packet link host
module testbench
    import dlspc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [5:0] RD_DT  = 6'h21;
    localparam logic [5:0] ERR_DT = 6'h02;
    localparam dlspc_pkt_t EOT_P  = {8'h01, 16'h0f0f, 2'h0, 6'h08};
    logic       clk_in = 1'b0, srst_in = 1'b1;
    logic       req_valid_in = 1'b0, end_of_transmission_packet_en_in = 1'b1;
    dlspc_pkt_t req_pkt_in = '0, rsp_pkt_out;
    logic       req_ready_out, rsp_valid_out, end_of_transmission_packet_seen_out, rx_tmo_out;
    logic       busy_out, lnk_clk_out, lnk_hs_out, lnk_dat_out;
    logic       lnk_dat_oe_out, p_dat, p_oe;
    wire        line_w = lnk_dat_oe_out ? lnk_dat_out : (p_oe & p_dat);
    int         n_fail = 0, comparisons = 0, eot_n, tmo_n, full_n;
    dlspc_pkt_t rsp_q[$], exp_q[$];
    // ------------------------------------------------------------------
    // Clock, design and peripheral
    // ------------------------------------------------------------------
    initial forever #2 clk_in = ~clk_in;
    dlspc_host #(.TMO_BITS(16)) dut_u (.clk_in(clk_in), .srst_in(srst_in),
        .req_pkt_in(req_pkt_in), .req_valid_in(req_valid_in),
        .req_ready_out(req_ready_out), .end_of_transmission_packet_en_in(end_of_transmission_packet_en_in),
        .rsp_pkt_out(rsp_pkt_out), .rsp_valid_out(rsp_valid_out),
        .end_of_transmission_packet_seen_out(end_of_transmission_packet_seen_out), .rx_tmo_out(rx_tmo_out),
        .busy_out(busy_out), .lnk_clk_out(lnk_clk_out),
        .lnk_hs_out(lnk_hs_out), .lnk_dat_in(line_w),
        .lnk_dat_out(lnk_dat_out), .lnk_dat_oe_out(lnk_dat_oe_out));
    dlspc_periph_model #(.RD_DT(RD_DT), .ERR_DT(ERR_DT)) periph_u (
        .srst_in(srst_in), .lnk_clk_in(lnk_clk_out), .lnk_hs_in(lnk_hs_out),
        .line_in(line_w), .host_oe_in(lnk_dat_oe_out), .dat_out(p_dat),
        .oe_out(p_oe));
    // Collect reply pulses; host must be off the line while we answer
    always @(posedge clk_in) begin
        if (rsp_valid_out === 1'b1) rsp_q.push_back(rsp_pkt_out);
        if (end_of_transmission_packet_seen_out === 1'b1) eot_n++;
        if (rx_tmo_out === 1'b1) tmo_n++;
        if (p_oe === 1'b1) chk_val(lnk_dat_oe_out, 0);
    end
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    // Offer one word and hold it until taken
    task automatic push(input dlspc_pkt_t p);
        int k = 0;
        req_pkt_in <= p;
        req_valid_in <= 1'b1;
        do begin
            @(posedge clk_in);
            k++;
            if (req_ready_out !== 1'b1) full_n++;
        end while (req_ready_out !== 1'b1 && k < 20000);
    endtask : push
    task automatic settle();
        int k = 0;
        req_valid_in <= 1'b0;
        repeat (60) @(posedge clk_in);
        while (busy_out !== 1'b0 && k < 30000) begin
            @(posedge clk_in);
            k++;
        end
        repeat (40) @(posedge clk_in);
    endtask : settle
    // One-parameter forms carry a zero pad byte on the wire
    function automatic dlspc_pkt_t wire_of(input dlspc_pkt_t p);
        wire_of = p;
        if (p.dt == 6'h13 || p.dt == 6'h14) wire_of.b1 = 8'h00;
    endfunction : wire_of
    task automatic check_wire();
        chk_val(periph_u.got_q.size(), exp_q.size());
        foreach (exp_q[i]) begin
            if (i < periph_u.got_q.size())
                chk_val(periph_u.got_q[i], exp_q[i]);
        end
        periph_u.got_q.delete();
        exp_q.delete();
    endtask : check_wire
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_codes();
        logic [5:0] c[11] = '{6'h01, 6'h11, 6'h21, 6'h31, 6'h12, 6'h22,
                              6'h32, 6'h02, 6'h03, 6'h13, 6'h23};
        dlspc_pkt_t p;
        foreach (c[i]) begin
            p = {8'h5a, 8'h77, 8'(i), 2'h3, c[i]};
            push(p);
            exp_q.push_back(wire_of(p));
        end
        exp_q.push_back(EOT_P);
        settle();
        check_wire();
        chk_val(periph_u.line_starts, 3);
    endtask : t_codes
    task automatic t_no_end();
        end_of_transmission_packet_en_in <= 1'b0;
        push({8'h11, 8'h00, 8'h00, 2'h0, 6'h31});
        exp_q.push_back({8'h11, 8'h00, 8'h00, 2'h0, 6'h31});
        settle();
        check_wire();
        end_of_transmission_packet_en_in <= 1'b1;
    endtask : t_no_end
    task automatic t_read(input int m, input int d, input logic [5:0] dt);
        dlspc_pkt_t rd = {8'h3c, 8'h99, 8'h42, 2'h1, dt};
        dlspc_pkt_t wr = {8'h3d, 8'h12, 8'h34, 2'h1, 6'h23};
        dlspc_pkt_t tl = {8'h3e, 8'h00, 8'h00, 2'h0, 6'h31};
        dlspc_pkt_t ex[$];
        dlspc_pkt_t rw;
        periph_u.mode = m;
        periph_u.delay = d;
        rsp_q.delete();
        eot_n = 0;
        tmo_n = 0;
        push(wr);
        push(rd);
        push(tl);
        exp_q = '{wire_of(wr), wire_of(rd), EOT_P, tl, EOT_P};
        settle();
        settle();
        check_wire();
        rw = wire_of(rd);
        if (m < 2) ex.push_back({8'h00, rw.b1, 8'h42, 2'h0, RD_DT});
        if (m == 1 || m == 2) ex.push_back({16'h0000, 8'h01, 2'h0, ERR_DT});
        chk_val(rsp_q.size(), ex.size());
        foreach (ex[i]) begin
            if (i < rsp_q.size()) chk_val(rsp_q[i], ex[i]);
        end
        chk_val(eot_n, m < 3);
        chk_val(tmo_n, m == 3);
    endtask : t_read
    task automatic t_fill();
        dlspc_pkt_t p;
        full_n = 0;
        for (int i = 0; i < 20; i++) begin
            p = {8'h20, 8'h00, 8'(i), 2'h2, 6'h21};
            push(p);
            exp_q.push_back(p);
        end
        exp_q.push_back(EOT_P);
        chk_val(full_n != 0, 1);
        settle();
        check_wire();
    endtask : t_fill
    // Watchdog well beyond the expected run length
    initial begin
        repeat (90000) @(posedge clk_in);
        n_fail++;
        stop_test();
    end
    initial begin
        repeat (8) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
        t_codes();
        t_no_end();
        t_read(0, 2, 6'h04);
        t_read(1, 10, 6'h14);
        t_read(2, 2, 6'h24);
        t_read(3, 2, 6'h04);
        t_fill();
        stop_test();
    end
endmodule : testbench
